/* File: bench/tb_top.sv */
// self-checking bench for the xor-into-target execute block
`timescale 1ns/10ps
module tb_top;
  logic ref_clk_i = 0, rst_b_i = 0, insn_valid_i = 0, zero_o, done_o;
  xafe_pkg::xafe_word_t insn_i = 12'h000;
  xafe_pkg::xafe_slot_t peek_slot_i = 5'h00;
  logic load_acc_i = 0, load_reg_i = 0;
  xafe_pkg::xafe_slot_t load_slot_i = 5'h00;
  xafe_pkg::xafe_byte_t load_data_i = 8'h00;
  xafe_pkg::xafe_byte_t acc_o, peek_data_o;
  int errors = 0, comparisons = 0;
  xafe_exec uut (.*);
  initial forever #5 ref_clk_i = ~ref_clk_i;
  // compare and count
  task automatic check(input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one word for one edge, results sampled after it
  task automatic issue(input logic [11:0] w);
    @(posedge ref_clk_i);
    insn_valid_i <= 1'b1;
    insn_i <= w;
    peek_slot_i <= w[4:0];
    @(posedge ref_clk_i);
    insn_valid_i <= 1'b0;
    #1;
  endtask : issue
  // preload accumulator or one data register, one edge
  task automatic preload(input logic to_reg, input logic [4:0] s,
                         input logic [7:0] d);
    @(posedge ref_clk_i);
    load_acc_i <= ~to_reg;
    load_reg_i <= to_reg;
    load_slot_i <= s;
    load_data_i <= d;
    @(posedge ref_clk_i);
    load_acc_i <= 1'b0;
    load_reg_i <= 1'b0;
  endtask : preload
  // register target on slot 5, then watch port
  task automatic t_to_reg;
    preload(1'b0, 5'h00, 8'hb5);
    preload(1'b1, 5'h05, 8'haf);
    issue(12'h1a5);
    check(done_o, 1'b1);
    check(zero_o, 1'b0);
    check(acc_o, 8'hb5);
    @(posedge ref_clk_i);
    #1;
    check(peek_data_o, 8'h1a);
    check(done_o, 1'b0);
  endtask : t_to_reg
  // acc target, then a refused word keeps state
  task automatic t_to_acc_refuse;
    issue(12'h185);
    check(acc_o, 8'haf);
    check(zero_o, 1'b0);
    @(posedge ref_clk_i);
    #1;
    check(peek_data_o, 8'h1a);
    preload(1'b1, 5'h05, 8'haf);
    issue(12'h185);
    check(acc_o, 8'h00);
    check(zero_o, 1'b1);
    issue(12'h0e5);
    check(done_o, 1'b0);
    check(zero_o, 1'b1);
    check(acc_o, 8'h00);
    preload(1'b1, 5'h1f, 8'h3c);
    issue(12'h1bf);
    check(zero_o, 1'b0);
    @(posedge ref_clk_i);
    #1;
    check(peek_data_o, 8'h3c);
  endtask : t_to_acc_refuse
  // closing report
  task automatic give_verdict;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // reset, scenarios, verdict
  initial begin
    repeat (16) @(posedge ref_clk_i);
    check(acc_o, 8'h00);
    check({zero_o, done_o}, 8'h00);
    rst_b_i <= 1'b1;
    t_to_reg;
    t_to_acc_refuse;
    give_verdict;
  end
endmodule : tb_top

/* File: bench/xafe_exec_checker.sv */
// port assertions for the xor-into-target execute block
`timescale 1ns/10ps
module xafe_chk (
  input wire logic                 ref_clk_i, rst_b_i, insn_valid_i,
  input wire logic                 load_acc_i,
  input wire logic                 zero_o, done_o,
  input wire xafe_pkg::xafe_word_t insn_i,
  input wire xafe_pkg::xafe_slot_t peek_slot_i,
  input wire xafe_pkg::xafe_byte_t acc_o, peek_data_o
);
  // executed word, and watch port on its slot
  wire ex = insn_valid_i && insn_i[11:6] == 6'h06;
  wire m  = peek_slot_i == insn_i[4:0];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_to_reg; ex && insn_i[5] && m ##1 $stable(peek_slot_i); endsequence
  sequence s_to_acc; ex && !insn_i[5] && m ##1 $stable(peek_slot_i); endsequence
  exec_done_a: assert property (ex |=> done_o)
    else $error("executed word gave no done");
  refuse_hold_a: assert property (!ex && !load_acc_i
    |=> !done_o && $stable(acc_o)
    && $stable(zero_o)) else $error("refused word changed state");
  acc_xor_a: assert property (ex && !insn_i[5] && m
    |=> acc_o == ($past(acc_o) ^ peek_data_o)) else $error("bad acc result");
  acc_keep_a: assert property (ex && insn_i[5] |=> $stable(acc_o))
    else $error("acc changed on register target");
  reg_write_a: assert property (s_to_reg
    |=> peek_data_o == ($past(acc_o) ^ $past(peek_data_o)))
    else $error("bad register result");
  reg_keep_a: assert property (s_to_acc |=> $stable(peek_data_o))
    else $error("register changed on acc target");
  acc_zero_a: assert property (ex && !insn_i[5]
    |=> zero_o == (acc_o == 8'h00)) else $error("bad zero flag");
  reg_zero_a: assert property (ex && insn_i[5] && m
    |=> zero_o == ((acc_o ^ peek_data_o) == 8'h00)) else $error("bad zero");
endmodule : xafe_chk
bind xafe_exec xafe_chk chk (.*);

/* File: design/xafe_decode.sv */
// decoder for the xor-into-target instruction word
`timescale 1ns/10ps
`include "xafe_map.svh"
module xafe_decode (
  // instruction word
  input  wire xafe_pkg::xafe_word_t insn_i,
  // decoded fields
  output logic                      hit_o,
  output logic                      dest_o,
  output xafe_pkg::xafe_slot_t      slot_o
);
  import xafe_pkg::*;

  // match opcode, split destination and slot
  always_comb begin
    hit_o  = (insn_i[`XAFE_OPC_HI:`XAFE_OPC_LO] == `XAFE_OPC_VAL); // [RL5]
    dest_o = insn_i[`XAFE_DEST_BIT];                                // [RL6]
    slot_o = insn_i[`XAFE_SLOT_HI:`XAFE_SLOT_LO];                   // [RL6]
  end
endmodule : xafe_decode

/* File: design/xafe_exec.sv */
// execute unit for the xor-into-target instruction
//
// Functional notes
// (RL1) xor accumulator with addressed data register
// (RL2) target bit 0: result into accumulator
// (RL3) target bit 1: result into data register
// (RL4) only zero flag changes, set when zero
// (RL5) opcode is upper six bits 000110
// (RL6) slot addresses registers 0 to 31
// (RL7) one word, one instruction cycle
// (RL8) zero flag from written result
`timescale 1ns/10ps
`include "xafe_map.svh"
module xafe_exec (
  // clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_b_i,
  // instruction issue
  input  wire logic                 insn_valid_i,
  input  wire xafe_pkg::xafe_word_t insn_i,
  // state preload, taken only while no word is issued
  input  wire logic                 load_acc_i,
  input  wire logic                 load_reg_i,
  input  wire xafe_pkg::xafe_slot_t load_slot_i,
  input  wire xafe_pkg::xafe_byte_t load_data_i,
  // architectural state
  output xafe_pkg::xafe_byte_t      acc_o,
  output logic                      zero_o,
  output logic                      done_o,
  // data register watch port
  input  wire xafe_pkg::xafe_slot_t peek_slot_i,
  output xafe_pkg::xafe_byte_t      peek_data_o
);
  import xafe_pkg::*;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic       hit;
  logic       dest;
  xafe_slot_t slot;
  logic       go;
  xafe_byte_t acc;
  xafe_byte_t file_q [0:31];
  xafe_byte_t result;
  logic       load_ok;
  xafe_byte_t next_acc;

  xafe_decode u_dec (
    .insn_i (insn_i),
    .hit_o  (hit),
    .dest_o (dest),
    .slot_o (slot)
  );

  // ---------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------
  // issue and operation result
  assign go     = insn_valid_i & hit;
  assign result = acc ^ file_q[slot]; // [RL1]
  // preload never competes with an issued word
  assign load_ok = ~insn_valid_i;

  // next accumulator: preload, result, or hold
  always_comb begin
    next_acc = acc;
    if (load_ok && load_acc_i) begin
      next_acc = load_data_i;
    end else if (go && dest == `XAFE_DEST_ACC) begin
      next_acc = result; // [RL2]
    end
  end

  // accumulator update
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc <= `XAFE_ACC_RST;
    end else begin
      acc <= next_acc; // [RL2]
    end
  end

  // data register file, written by an executed word when target bit is 1, or by preload
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_file
      always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          file_q[gi] <= `XAFE_REG_RST;
        end else if (go && dest == `XAFE_DEST_REG &&
                     slot == xafe_slot_t'(gi)) begin
          file_q[gi] <= result; // [RL3] [RL6]
        end else if (load_ok && load_reg_i &&
                     load_slot_i == xafe_slot_t'(gi)) begin
          file_q[gi] <= load_data_i;
        end
      end
    end
  endgenerate

  // zero flag, only status bit touched
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      zero_o <= `XAFE_ZERO_RST;
    end else if (go) begin
      zero_o <= (result == 8'h00); // [RL4] [RL8]
    end
  end

  // single-cycle completion strobe
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= go; // [RL7]
    end
  end

  // registered views of state
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_o       <= `XAFE_ACC_RST;
      peek_data_o <= `XAFE_REG_RST;
    end else begin
      acc_o       <= next_acc;
      peek_data_o <= file_q[peek_slot_i];
    end
  end
endmodule : xafe_exec

/* File: design/xafe_map.svh */
// constants for the xor-into-target execute block
`ifndef XAFE_MAP_SVH
`define XAFE_MAP_SVH
`define XAFE_OPC_HI        11
`define XAFE_OPC_LO        6
`define XAFE_OPC_VAL       6'h06
`define XAFE_DEST_BIT      5
`define XAFE_SLOT_HI       4
`define XAFE_SLOT_LO       0
`define XAFE_ACC_RST       8'h00
`define XAFE_REG_RST       8'h00
`define XAFE_ZERO_RST      1'b0
`define XAFE_DEST_ACC      1'b0
`define XAFE_DEST_REG      1'b1
`endif

/* File: design/xafe_pkg.sv */
// types for the xor-into-target execute block
package xafe_pkg;
  typedef logic [7:0]  xafe_byte_t;
  typedef logic [11:0] xafe_word_t;
  typedef logic [4:0]  xafe_slot_t;
endpackage : xafe_pkg
